// *** core/tws_pkg.sv ***
// Package: register map, field positions, reset values and carrier structs
package tws_pkg;
    // Register byte addresses
    localparam logic [15:0] ADDR_MODE_SETTING = 16'h43c2;
    localparam logic [15:0] ADDR_BIT_RATE = 16'h43c4;
    localparam logic [15:0] ADDR_OWN_ADDRESS = 16'h43c8;
    localparam logic [15:0] ADDR_CHANNEL_CONTROL = 16'h43ca;
    localparam logic [15:0] ADDR_OUTGOING_BYTE = 16'h43cc;
    localparam logic [15:0] ADDR_INCOMING_BYTE = 16'h43ce;
    localparam logic [15:0] ADDR_FLAGS = 16'h43d0;
    localparam logic [15:0] ADDR_EVENT_ENABLES = 16'h43d2;
    // Mode register bits
    localparam int MODE_TEN_BIT_POS = 2;
    localparam int MODE_GC_ACCEPT_POS = 1;
    // Control register bits
    localparam int CTL_ROLE_POS = 5;
    localparam int CTL_NACK_POS = 4;
    localparam int CTL_STOP_POS = 3;
    localparam int CTL_START_POS = 2;
    localparam int CTL_SOFT_RST_POS = 1;
    localparam int CTL_ENABLE_POS = 0;
    // Status bits in the flag register
    localparam int ST_SDA_LOW_POS = 12;
    localparam int ST_SCL_LOW_POS = 11;
    localparam int ST_BUSY_POS = 10;
    localparam int ST_SENDING_POS = 9;
    // Event flag bits
    localparam int FLAG_BYTE_DONE_POS = 7;
    localparam int FLAG_RX_FULL_POS = 1;
    localparam int FLAG_TX_EMPTY_POS = 0;
    // Flags cleared by writing one (bits 7..2)
    localparam logic [7:0] FLAG_W1C_MASK = 8'hfc;
    // Reset values
    localparam logic [6:0] BIT_RATE_RST = 7'h7f;
    localparam logic [9:0] OWN_ADDR_RST = 10'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ENABLES_RST = 8'h00;

    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tws_bus_req_s;

    // Events and status from the serial engine
    typedef struct packed {
        logic byte_done;
        logic general_call;
        logic not_ack;
        logic stop_seen;
        logic start_seen;
        logic error;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic tx_taken;
        logic data_line_held_low;
        logic clock_line_held_low;
        logic busy;
        logic sending_role;
        logic secondary_reset_source;
    } tws_engine_s;

    // Configuration towards the serial engine
    typedef struct packed {
        logic ten_bit_self_addr_select;
        logic general_call_accept;
        logic [6:0] bit_rate_divisor;
        logic [9:0] own_address_value;
        logic controller_role;
        logic send_not_ack_request;
        logic send_stop_request;
        logic send_start_request;
        logic soft_reset_request;
        logic channel_enable;
        logic [7:0] tx_byte;
    } tws_config_s;
endpackage : tws_pkg

// *** core/tws_regs.sv ***
// Register bank of one two-wire serial channel
// Functional notes
// - Six event flags cleared by writing one
// - Receive-full flag read-only, cleared by data read
// - Transmit-empty flag read-only, cleared by data write
// - Bit-rate divisor bits 6..0, reset 0x7f
// - Own address bits 9..0, reset zero
// - Ten-bit address select at mode bit 2
// - Role, soft reset, enable at bits 5,1,0
// - Nack/stop/start requests, cleared by both resets
// - Transmit byte bits 7..0, reset zero
// - Receive byte bits 7..0 read-only
// - Enable bits mirror flag positions 7..0
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tws_regs
    import tws_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire tws_bus_req_s bus_req,
    output logic [15:0] rdata,
    // Serial engine side
    input wire tws_engine_s engine,
    output tws_config_s cfg,
    // Interrupt request
    output logic irq
);

    // Mode bits
    logic ten_bit_ff;
    logic gc_accept_ff;
    // Bit rate and own address
    logic [6:0] bit_rate_ff;
    logic [9:0] own_addr_ff;
    // Control bits
    logic role_ff;
    logic nack_req_ff;
    logic stop_req_ff;
    logic start_req_ff;
    logic soft_rst_ff;
    logic enable_ff;
    // Data bytes
    logic [7:0] tx_byte_ff;
    logic [7:0] rx_byte_ff;
    // Flags and enables
    logic [7:0] flags_ff;
    logic [7:0] enables_ff;
    logic [7:0] nxt_flags;
    logic [7:0] event_set;
    // Status mirror
    logic [3:0] status_ff;
    // Read data register
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    // Decoded strobes
    logic wr_mode, wr_rate, wr_addr, wr_ctl, wr_tx, wr_flags, wr_en, rd_rx;

    // Address decode
    always_comb begin
        wr_mode = bus_req.wr && (bus_req.addr == ADDR_MODE_SETTING);
        wr_rate = bus_req.wr && (bus_req.addr == ADDR_BIT_RATE);
        wr_addr = bus_req.wr && (bus_req.addr == ADDR_OWN_ADDRESS);
        wr_ctl = bus_req.wr && (bus_req.addr == ADDR_CHANNEL_CONTROL);
        wr_tx = bus_req.wr && (bus_req.addr == ADDR_OUTGOING_BYTE);
        wr_flags = bus_req.wr && (bus_req.addr == ADDR_FLAGS);
        wr_en = bus_req.wr && (bus_req.addr == ADDR_EVENT_ENABLES);
        rd_rx = bus_req.rd && (bus_req.addr == ADDR_INCOMING_BYTE);
    end

    // Mode register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ten_bit_ff <= 1'b0;
            gc_accept_ff <= 1'b0;
        end else if (wr_mode) begin
            ten_bit_ff <= bus_req.wdata[MODE_TEN_BIT_POS];
            gc_accept_ff <= bus_req.wdata[MODE_GC_ACCEPT_POS];
        end
    end

    // Bit-rate and own address
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_rate_ff <= BIT_RATE_RST;
            own_addr_ff <= OWN_ADDR_RST;
        end else begin
            if (wr_rate) begin
                bit_rate_ff <= bus_req.wdata[6:0];
            end
            if (wr_addr) begin
                own_addr_ff <= bus_req.wdata[9:0];
            end
        end
    end

    // Control: role, soft reset and enable use hardware reset only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            role_ff <= 1'b0;
            soft_rst_ff <= 1'b0;
            enable_ff <= 1'b0;
        end else if (wr_ctl) begin
            role_ff <= bus_req.wdata[CTL_ROLE_POS];
            soft_rst_ff <= bus_req.wdata[CTL_SOFT_RST_POS];
            enable_ff <= bus_req.wdata[CTL_ENABLE_POS];
        end
    end

    // Control: condition requests also cleared by secondary reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n || engine.secondary_reset_source) begin
            nack_req_ff <= 1'b0;
            stop_req_ff <= 1'b0;
            start_req_ff <= 1'b0;
        end else if (wr_ctl) begin
            nack_req_ff <= bus_req.wdata[CTL_NACK_POS];
            stop_req_ff <= bus_req.wdata[CTL_STOP_POS];
            start_req_ff <= bus_req.wdata[CTL_START_POS];
        end
    end

    // Transmit byte
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_byte_ff <= BYTE_RST;
        end else if (wr_tx) begin
            tx_byte_ff <= bus_req.wdata[7:0];
        end
    end

    // Receive byte from engine
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_byte_ff <= BYTE_RST;
        end else if (engine.rx_valid) begin
            rx_byte_ff <= engine.rx_byte;
        end
    end

    // Status mirror, busy also cleared by secondary reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_ff <= 4'h0;
        end else begin
            status_ff <= {engine.data_line_held_low, engine.clock_line_held_low,
                          engine.busy && !engine.secondary_reset_source,
                          engine.sending_role};
        end
    end

    // Event sources in flag bit order
    always_comb begin
        event_set = {engine.byte_done, engine.general_call, engine.not_ack,
                     engine.stop_seen, engine.start_seen, engine.error,
                     engine.rx_valid, engine.tx_taken};
    end

    // Flag clears, with set winning over clear per bit
    generate
        for (genvar i = 0; i < 8; i++) begin : g_flag
            always_comb begin
                if (event_set[i]) begin
                    nxt_flags[i] = 1'b1;
                end else if (FLAG_W1C_MASK[i] && wr_flags && bus_req.wdata[i]) begin
                    nxt_flags[i] = 1'b0;
                end else if (i == FLAG_RX_FULL_POS && rd_rx) begin
                    nxt_flags[i] = 1'b0;
                end else if (i == FLAG_TX_EMPTY_POS && wr_tx) begin
                    nxt_flags[i] = 1'b0;
                end else begin
                    nxt_flags[i] = flags_ff[i];
                end
            end
        end
    endgenerate

    // Flag register, also cleared by secondary reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n || engine.secondary_reset_source) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Enable register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            enables_ff <= ENABLES_RST;
        end else if (wr_en) begin
            enables_ff <= bus_req.wdata[7:0];
        end
    end

    // Read multiplexer, unmapped reads zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_MODE_SETTING: begin
                    nxt_rdata[MODE_TEN_BIT_POS] = ten_bit_ff;
                    nxt_rdata[MODE_GC_ACCEPT_POS] = gc_accept_ff;
                end
                ADDR_BIT_RATE: nxt_rdata[6:0] = bit_rate_ff;
                ADDR_OWN_ADDRESS: nxt_rdata[9:0] = own_addr_ff;
                ADDR_CHANNEL_CONTROL: begin
                    nxt_rdata[5:0] = {role_ff, nack_req_ff, stop_req_ff,
                                      start_req_ff, soft_rst_ff, enable_ff};
                end
                ADDR_OUTGOING_BYTE: nxt_rdata[7:0] = tx_byte_ff;
                ADDR_INCOMING_BYTE: nxt_rdata[7:0] = rx_byte_ff;
                ADDR_FLAGS: begin
                    nxt_rdata[12:9] = status_ff;
                    nxt_rdata[7:0] = flags_ff;
                end
                ADDR_EVENT_ENABLES: nxt_rdata[7:0] = enables_ff;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs
    always_comb begin
        rdata = rdata_ff;
        irq = |(flags_ff & enables_ff);
        cfg.ten_bit_self_addr_select = ten_bit_ff;
        cfg.general_call_accept = gc_accept_ff;
        cfg.bit_rate_divisor = bit_rate_ff;
        cfg.own_address_value = own_addr_ff;
        cfg.controller_role = role_ff;
        cfg.send_not_ack_request = nack_req_ff;
        cfg.send_stop_request = stop_req_ff;
        cfg.send_start_request = start_req_ff;
        cfg.soft_reset_request = soft_rst_ff;
        cfg.channel_enable = enable_ff;
        cfg.tx_byte = tx_byte_ff;
    end

    // Write-one clears a flag absent a new event
    w1c_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_flags && bus_req.wdata[FLAG_BYTE_DONE_POS] && !engine.byte_done
         && !engine.secondary_reset_source) |=> !flags_ff[FLAG_BYTE_DONE_POS])
        else $error("byte done flag not cleared by write one");
    // Writing zero keeps flag
    w0_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_flags && !bus_req.wdata[FLAG_BYTE_DONE_POS] && !engine.secondary_reset_source
         && flags_ff[FLAG_BYTE_DONE_POS]) |=> flags_ff[FLAG_BYTE_DONE_POS])
        else $error("flag lost on write zero");
    // Receive read clears full flag
    rx_read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_rx && !engine.rx_valid) |=> !flags_ff[FLAG_RX_FULL_POS])
        else $error("receive full not cleared by read");
    // Transmit write clears empty flag
    tx_write_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_tx && !engine.tx_taken) |=> !flags_ff[FLAG_TX_EMPTY_POS])
        else $error("transmit empty not cleared by write");
    // Bit rate readback upper bits zero
    rate_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus_req.rd && bus_req.addr == ADDR_BIT_RATE) |=>
        (rdata == {9'h000, $past(bit_rate_ff)}))
        else $error("bit rate readback wrong");
    // Own address write lands
    addr_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_addr |=> (own_addr_ff == $past(bus_req.wdata[9:0])))
        else $error("own address write lost");
    // Secondary reset clears requests
    req_sec_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        engine.secondary_reset_source |=> !(nack_req_ff || stop_req_ff || start_req_ff))
        else $error("requests survive secondary reset");
    // Interrupt follows enabled flags
    irq_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en && |(bus_req.wdata[7:0] & flags_ff) && !engine.secondary_reset_source
         && !wr_flags) |=> irq)
        else $error("interrupt missing for enabled flag");
    // Bit rate holds its reset value when reset lifts
    rate_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> (bit_rate_ff == BIT_RATE_RST))
        else $error("bit rate not at reset value");
    // Own address clear when reset lifts
    addr_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> (own_addr_ff == OWN_ADDR_RST))
        else $error("own address not at reset value");
    // Data bytes clear when reset lifts
    byte_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> (tx_byte_ff == BYTE_RST && rx_byte_ff == BYTE_RST))
        else $error("data bytes not at reset value");
    // Flags clear when reset lifts, transmit-empty included
    flag_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> (flags_ff == FLAGS_RST))
        else $error("flags not at reset value");
    // Control bits clear when reset lifts
    ctl_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> !(role_ff || soft_rst_ff || enable_ff
         || nack_req_ff || stop_req_ff || start_req_ff))
        else $error("control bits not at reset value");
    // Mode bits clear when reset lifts
    mode_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> !(ten_bit_ff || gc_accept_ff))
        else $error("mode bits not at reset value");
    // Status mirror clear when reset lifts
    status_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> (status_ff == 4'h0))
        else $error("status bits not at reset value");
    // Enables clear when reset lifts
    en_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> (enables_ff == ENABLES_RST))
        else $error("enables not at reset value");
    // Write-one clears every self-clearing flag that has no new event
    w1c_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_flags && !engine.secondary_reset_source) |=> ((flags_ff & FLAG_W1C_MASK
         & $past(bus_req.wdata[7:0]) & ~$past(event_set)) == 8'h00))
        else $error("write one left a flag set");
    // Flag writes never clear the receive-full and transmit-empty bits
    ro_flag_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_flags && !engine.secondary_reset_source) |=>
        ((flags_ff[1:0] & $past(flags_ff[1:0])) == $past(flags_ff[1:0])))
        else $error("read-only flag cleared by write");
    // Events set their flags, also against a clear
    flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|event_set && !engine.secondary_reset_source) |=>
        ((flags_ff & $past(event_set)) == $past(event_set)))
        else $error("event did not set its flag");
    // Receive data read shows the latched byte, upper byte zero
    rx_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_rx |=> (rdata == {8'h00, $past(rx_byte_ff)}))
        else $error("receive byte readback wrong");
    // Transmit byte write lands
    tx_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_tx |=> (tx_byte_ff == $past(bus_req.wdata[7:0])))
        else $error("transmit byte write lost");
    // Secondary reset leaves role, soft reset and enable alone
    ctl_keep_sec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (engine.secondary_reset_source && !wr_ctl) |=>
        ($stable(role_ff) && $stable(soft_rst_ff) && $stable(enable_ff)))
        else $error("control bit lost on secondary reset");
    // Secondary reset clears the busy mirror
    busy_sec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        engine.secondary_reset_source |=> !status_ff[ST_BUSY_POS - ST_SENDING_POS])
        else $error("busy survives secondary reset");
    // Masking all enables drops the interrupt
    irq_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en && bus_req.wdata[7:0] == 8'h00) |=> !irq)
        else $error("interrupt stays with all enables off");
    // Enable write lands
    en_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_en |=> (enables_ff == $past(bus_req.wdata[7:0])))
        else $error("enable write lost");
    // Ten-bit select write lands
    ten_bit_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_mode |=> (ten_bit_ff == $past(bus_req.wdata[MODE_TEN_BIT_POS])))
        else $error("ten-bit select write lost");
    // General-call accept write lands
    gc_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_mode |=> (gc_accept_ff == $past(bus_req.wdata[MODE_GC_ACCEPT_POS])))
        else $error("general-call accept write lost");
    // Secondary reset clears all flags
    flags_sec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        engine.secondary_reset_source |=> (flags_ff == FLAGS_RST))
        else $error("flags survive secondary reset");

endmodule : tws_regs
`default_nettype wire

// *** sim/two_wire_serial_register_bank_tb.sv ***
// Self-checking bench for the two-wire serial register bank
`timescale 1ns/1ps
`default_nettype none
module two_wire_serial_register_bank_tb
    import tws_pkg::*;
();
    // Clock, reset and design ports
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    tws_bus_req_s bus_req = '0;
    tws_engine_s engine = '0;
    logic [15:0] rdata;
    tws_config_s cfg;
    logic irq;
    // Scoreboard state
    logic [15:0] exp_q[$];
    logic rd_seen = 1'b0;
    int fail_count = 0;
    int samples_checked = 0;
    logic [15:0] rnd;
    logic [15:0] wv [9];
    logic [7:0] rb;
    // Register table: address, reset value, writable mask; last one unmapped
    logic [15:0] ad [9] = '{ADDR_MODE_SETTING, ADDR_BIT_RATE, ADDR_OWN_ADDRESS,
        ADDR_CHANNEL_CONTROL, ADDR_OUTGOING_BYTE, ADDR_INCOMING_BYTE, ADDR_FLAGS,
        ADDR_EVENT_ENABLES, 16'h43c6};
    logic [15:0] rv [9] = '{16'h0000, 16'h007f, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] mv [9] = '{16'h0006, 16'h007f, 16'h03ff, 16'h003f, 16'h00ff,
        16'h0000, 16'h0000, 16'h00ff, 16'h0000};

    // Free-running 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    tws_regs tws_regs_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .engine(engine), .cfg(cfg), .irq(irq));

    // Read data compare
    task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] rdata expected %h seen %h", e, g);
        end
    endtask : chk_rd

    // Output level compare
    task automatic chk_out(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_out

    // Bus write, one cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    // Bus read, expectation noted for the monitor
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
    endtask : rd

    // Bus quiet for n more cycles
    task automatic idle(input int n);
        @(posedge ref_clk);
        bus_req <= '0;
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // One-cycle engine events, mask in flag bit order
    task automatic ev(input logic [7:0] m, input logic [7:0] b);
        @(posedge ref_clk);
        bus_req <= '0;
        {engine.byte_done, engine.general_call, engine.not_ack, engine.stop_seen,
            engine.start_seen, engine.error, engine.rx_valid, engine.tx_taken} <= m;
        engine.rx_byte <= b;
        @(posedge ref_clk);
        {engine.byte_done, engine.general_call, engine.not_ack, engine.stop_seen,
            engine.start_seen, engine.error, engine.rx_valid, engine.tx_taken} <= 8'h00;
    endtask : ev

    // Line and busy levels from the engine
    task automatic lv(input logic [3:0] v);
        @(posedge ref_clk);
        {engine.data_line_held_low, engine.clock_line_held_low, engine.busy,
            engine.sending_role} <= v;
    endtask : lv

    // Interrupt level, sampled mid-cycle
    task automatic chk_irq(input logic e);
        @(negedge ref_clk);
        chk_out("irq", {15'h0000, e}, {15'h0000, irq});
    endtask : chk_irq

    // Verdict and end of run
    task automatic tally_and_finish();
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("[ERR] rdata expected %0d more reads seen none", exp_q.size());
        end
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // Monitor: read data stand the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("[ERR] rdata expected none seen %h", rdata);
            end else begin
                chk_rd(exp_q.pop_front(), rdata);
            end
        end
        rd_seen <= bus_req.rd;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("[ERR] watchdog expected done seen hang");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        void'($urandom(7447));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values, unmapped read, interrupt idle
        for (int i = 0; i < 9; i++) rd(ad[i], rv[i]);
        idle(2);
        @(negedge ref_clk);
        chk_out("rate", 16'h007f, {9'h000, cfg.bit_rate_divisor});
        chk_irq(1'b0);
        $display("test reset_values done");
        // All-ones then random writes, read back through the field masks
        for (int i = 0; i < 9; i++) begin
            rnd = 16'($urandom());
            wv[i] = rnd;
            wr(ad[i], 16'hffff);
            rd(ad[i], mv[i]);
            wr(ad[i], rnd);
            rd(ad[i], rnd & mv[i]);
        end
        idle(2);
        @(negedge ref_clk);
        chk_out("rate", wv[1] & 16'h007f, {9'h000, cfg.bit_rate_divisor});
        chk_out("mode", {14'h0000, wv[0][2:1]},
            {14'h0000, cfg.ten_bit_self_addr_select, cfg.general_call_accept});
        chk_out("addr", wv[2] & 16'h03ff, {6'h00, cfg.own_address_value});
        chk_out("ctl", wv[3] & 16'h003f, {10'h000, cfg.controller_role,
            cfg.send_not_ack_request, cfg.send_stop_request, cfg.send_start_request,
            cfg.soft_reset_request, cfg.channel_enable});
        chk_out("txb", wv[4] & 16'h00ff, {8'h00, cfg.tx_byte});
        $display("test access_masks done");
        // Flags: set, write-zero, write-one, side-effect clears
        wr(ADDR_EVENT_ENABLES, 16'h0000);
        rb = 8'($urandom());
        ev(8'hff, rb);
        lv(4'hf);
        idle(2);
        rd(ADDR_FLAGS, 16'h1eff);
        wr(ADDR_FLAGS, 16'h0000);
        rd(ADDR_FLAGS, 16'h1eff);
        wr(ADDR_FLAGS, 16'h0087);
        rd(ADDR_FLAGS, 16'h1e7b);
        rd(ADDR_INCOMING_BYTE, {8'h00, rb});
        rd(ADDR_FLAGS, 16'h1e79);
        wr(ADDR_OUTGOING_BYTE, 16'h00a5);
        rd(ADDR_FLAGS, 16'h1e78);
        wr(ADDR_FLAGS, 16'h00fc);
        rd(ADDR_FLAGS, 16'h1e00);
        idle(0);
        chk_irq(1'b0);
        lv(4'h0);
        idle(2);
        rd(ADDR_FLAGS, 16'h0000);
        idle(2);
        $display("test flags done");
        // Interrupt per flag: raise, mask, unmask, clear
        for (int i = 0; i < 8; i++) begin
            rb = 8'($urandom());
            wr(ADDR_EVENT_ENABLES, 16'h0001 << i);
            ev(8'h01 << i, rb);
            idle(1);
            chk_irq(1'b1);
            wr(ADDR_EVENT_ENABLES, 16'h0000);
            idle(1);
            chk_irq(1'b0);
            wr(ADDR_EVENT_ENABLES, 16'h0001 << i);
            if (i >= 2) wr(ADDR_FLAGS, 16'h0001 << i);
            else if (i == 1) rd(ADDR_INCOMING_BYTE, {8'h00, rb});
            else wr(ADDR_OUTGOING_BYTE, {8'h00, rb});
            idle(1);
            chk_irq(1'b0);
        end
        $display("test interrupts done");
        // Secondary reset held, then a hardware reset mid-run
        wr(ADDR_CHANNEL_CONTROL, 16'h003f);
        ev(8'hfc, 8'h00);
        lv(4'hf);
        @(posedge ref_clk);
        engine.secondary_reset_source <= 1'b1;
        idle(2);
        rd(ADDR_CHANNEL_CONTROL, 16'h0023);
        rd(ADDR_FLAGS, 16'h1a00);
        idle(0);
        engine.secondary_reset_source <= 1'b0;
        lv(4'h0);
        ev(8'hff, 8'h5a);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        rd(ADDR_CHANNEL_CONTROL, 16'h0000);
        rd(ADDR_BIT_RATE, 16'h007f);
        rd(ADDR_EVENT_ENABLES, 16'h0000);
        rd(ADDR_FLAGS, 16'h0000);
        rd(ADDR_INCOMING_BYTE, 16'h0000);
        rd(ADDR_OWN_ADDRESS, 16'h0000);
        rd(ADDR_MODE_SETTING, 16'h0000);
        rd(ADDR_OUTGOING_BYTE, 16'h0000);
        idle(3);
        $display("test resets done");
        tally_and_finish();
    end
endmodule : two_wire_serial_register_bank_tb
`default_nettype wire
